// *** core/ovr_pkg.sv ***
package ovr_pkg;
    localparam logic [7:0] IMB_TRIM_OFS   = 8'h14;
    localparam logic [7:0] OVERRANGE_ENABLE_OFS     = 8'h3a;
    localparam logic [7:0] OVERRANGE_HOLD_CTL_OFS   = 8'h3b;
    localparam logic [7:0] OVERRANGE_THRESHOLD_OFS     = 8'h3c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h40;
    localparam logic [7:0] IRQ_CLEAR_OFS  = 8'h41;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h42;
    localparam logic [7:0] REG_RESET      = 8'h00;

    localparam int AMP_MSB    = 6;
    localparam int AMP_LSB    = 4;
    localparam int PH_MSB     = 3;
    localparam int PH_LSB     = 0;
    localparam int OVERRANGE_ENABLE_BIT = 0;
    localparam int HOLD_MSB   = 1;
    localparam int IRQ_W      = 2;
    localparam int IRQ_ONSET  = 0;
    localparam int IRQ_FALL   = 1;

    localparam logic [2:0]  AMP_RESERVED  = 3'h4;
    localparam logic [3:0]  PH_RESERVED   = 4'h8;
    localparam logic [7:0]  TERM_STEP_OHM = 8'h0a;
    localparam logic [10:0] CAP_STEP_FF   = 11'h0f0;
    localparam logic [3:0]  HOLD_EXT_0    = 4'h0;
    localparam logic [3:0]  HOLD_EXT_1    = 4'h3;
    localparam logic [3:0]  HOLD_EXT_2    = 4'h7;
    localparam logic [3:0]  HOLD_EXT_3    = 4'hf;
    localparam int          TH_SHIFT      = 7;
    localparam int          OVR_LATENCY   = 3;
    localparam logic signed [16:0] FS_POS = 17'sh07fff;
    localparam logic signed [16:0] FS_NEG = 17'sh18000;

    function automatic logic [3:0] hold_ext(input logic [1:0] code);
        case (code)
            2'h0:    hold_ext = HOLD_EXT_0;
            2'h1:    hold_ext = HOLD_EXT_1;
            2'h2:    hold_ext = HOLD_EXT_2;
            default: hold_ext = HOLD_EXT_3;
        endcase
    endfunction
endpackage

// *** core/trim_decode.sv ***
`timescale 1ns/1ns
module trim_decode
    import ovr_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [7:0]        trim_i,
    output logic signed [7:0]      pos_term_ohm_o,
    output logic signed [7:0]      neg_term_ohm_o,
    output logic [10:0]            pos_cap_ff_o,
    output logic [10:0]            neg_cap_ff_o,
    output logic                   trim_reserved_o
);
    typedef struct packed {
        logic [7:0]  pos_ohm;
        logic [7:0]  neg_ohm;
        logic [10:0] pos_cap;
        logic [10:0] neg_cap;
        logic        rsvd;
    } trim_st_t;
    trim_st_t st, next_st;
    logic [2:0]  amp;
    logic [3:0]  ph;
    logic [7:0]  mag;
    logic [10:0] cap;

    assign amp = trim_i[AMP_MSB:AMP_LSB];
    assign ph  = trim_i[PH_MSB:PH_LSB];

    always_comb begin
        // codes 5..7 and 1..3 share the low two bits as step count
        mag = 8'(amp[1:0]) * TERM_STEP_OHM;
        cap = 11'(ph[2:0]) * CAP_STEP_FF;
        next_st.pos_ohm = amp[2] ? mag : 8'(-mag);
        next_st.neg_ohm = amp[2] ? 8'(-mag) : mag;
        next_st.pos_cap = ph[3] ? 11'h000 : cap;
        next_st.neg_cap = ph[3] ? cap : 11'h000;
        // reserved codes apply no change
        next_st.rsvd = (amp == AMP_RESERVED) || (ph == PH_RESERVED);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pos_term_ohm_o  = st.pos_ohm;
    assign neg_term_ohm_o  = st.neg_ohm;
    assign pos_cap_ff_o    = st.pos_cap;
    assign neg_cap_ff_o    = st.neg_cap;
    assign trim_reserved_o = st.rsvd;
endmodule

// *** core/overrange_hold.sv ***
`timescale 1ns/1ns
module overrange_hold
    import ovr_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       sample_en_i,
    input  wire logic       raw_i,
    input  wire logic [1:0] hold_code_i,
    input  wire logic       clear_i,
    output logic            indicator_o
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       ind;
    } hold_st_t;
    hold_st_t st, next_st;

    always_comb begin
        next_st = st;
        if (clear_i) begin
            next_st = '0;
        end else if (sample_en_i) begin
            if (raw_i) begin
                next_st.ind = 1'b1;
                next_st.cnt = hold_ext(hold_code_i);
            end else if (st.cnt != 4'h0) begin
                next_st.cnt = 4'(st.cnt - 4'h1);
                next_st.ind = 1'b1;
            end else begin
                next_st.ind = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign indicator_o = st.ind;

    hold_restart_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sample_en_i && raw_i && !clear_i) |=> (st.ind && st.cnt == hold_ext($past(hold_code_i))))
        else $error("hold count not restarted on new event");
    sample_paced_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $changed(st.ind) |-> ($past(sample_en_i) || $past(clear_i)))
        else $error("indicator moved without a sampling tick");
endmodule

// *** core/input_trim_overrange_regs.sv ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns

// Notes on behaviour
// - Amplitude code 5..7 moves the positive termination up and the negative down by 10/20/30 ohm, 1..3 the reverse, 0 none, 4 reserved.
// - Phase code 1..7 loads the positive input with 0.24 pF steps up to 1.68 pF, 9..15 the negative input, 0 none, 8 reserved.
// - With the enable bit clear detection is off; with it set the indicator is driven on the serial data pin.
// - A sample beyond the threshold is an over-range event and raises the indicator.
// - After the input falls back the indicator stays up 0, 3, 7 or 15 extra cycles per the hold code.
// - The hold extension counts sampling clock periods, not reference clock periods.
// - The enable register resets to zero so detection starts disabled.
// - The hold register resets to zero so there is no extension until programmed.
// - Thresholds sit the threshold value times 128 codes inside each full-scale extreme; zero means full scale.
module input_trim_overrange_regs
    import ovr_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [7:0]             reg_rdata_o,
    input  wire logic [15:0]       sample_i,
    input  wire logic              sample_valid_i,
    output logic                   overrange_indicator_o,
    output logic                   serial_data_out_pin_o,
    output logic                   serial_data_out_pin_oe_o,
    output logic signed [7:0]      pos_term_ohm_o,
    output logic signed [7:0]      neg_term_ohm_o,
    output logic [10:0]            pos_cap_ff_o,
    output logic [10:0]            neg_cap_ff_o,
    output logic                   trim_reserved_o,
    output logic                   irq_o
);

    typedef struct packed {
        logic [7:0]             imb;
        logic [7:0]             en;
        logic [7:0]             hold;
        logic [7:0]             th;
        logic [IRQ_W-1:0]       irq_status;
        logic [IRQ_W-1:0]       irq_enable;
        logic [7:0]             rdata;
        logic [OVR_LATENCY-1:0] dly;
        logic                   ind_prev;
        logic [4:0]             run;
    } state_t;

    state_t st;
    state_t next_st;

    logic                   en_bit;
    logic [1:0]             hold_code;
    logic [14:0]            thr_mag;
    logic signed [16:0]     thr_hi;
    logic signed [16:0]     thr_lo;
    logic signed [16:0]     s_ext;
    logic                   over_raw;
    logic                   raw_late;
    logic                   ind;
    logic                   onset;
    logic                   fall;
    logic [IRQ_W-1:0]       clr;

    assign en_bit    = st.en[OVERRANGE_ENABLE_BIT];
    assign hold_code = st.hold[HOLD_MSB:0];

    // threshold magnitude is value x 128, pulled in from both clip codes
    assign thr_mag = 15'({st.th, 7'h00}) >> (7 - TH_SHIFT);
    assign thr_hi  = 17'(FS_POS - $signed({2'b00, thr_mag}));
    assign thr_lo  = 17'(FS_NEG + $signed({2'b00, thr_mag}));
    assign s_ext   = $signed({sample_i[15], sample_i});

    // at or beyond the threshold counts, so full scale catches clip codes
    assign over_raw = (s_ext >= thr_hi) || (s_ext <= thr_lo);

    assign raw_late = st.dly[OVR_LATENCY-1];

    trim_decode u_trim (
        .sys_clk_i       (sys_clk_i),
        .resetn_i        (resetn_i),
        .trim_i          (st.imb),
        .pos_term_ohm_o  (pos_term_ohm_o),
        .neg_term_ohm_o  (neg_term_ohm_o),
        .pos_cap_ff_o    (pos_cap_ff_o),
        .neg_cap_ff_o    (neg_cap_ff_o),
        .trim_reserved_o (trim_reserved_o)
    );

    overrange_hold u_hold (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .sample_en_i (sample_valid_i),
        .raw_i       (raw_late),
        .hold_code_i (hold_code),
        .clear_i     (!en_bit),
        .indicator_o (ind)
    );

    assign onset = ind && !st.ind_prev;
    assign fall  = !ind && st.ind_prev;

    always_comb begin
        next_st          = st;
        next_st.rdata    = 8'h00;
        next_st.ind_prev = ind;
        clr              = '0;

        if (reg_wr_i) begin
            case (reg_addr_i)
                IMB_TRIM_OFS:   next_st.imb = reg_wdata_i;
                OVERRANGE_ENABLE_OFS:     next_st.en = reg_wdata_i;
                OVERRANGE_HOLD_CTL_OFS:   next_st.hold = reg_wdata_i;
                OVERRANGE_THRESHOLD_OFS:     next_st.th = reg_wdata_i;
                IRQ_CLEAR_OFS:  clr = reg_wdata_i[IRQ_W-1:0];
                IRQ_ENABLE_OFS: next_st.irq_enable = reg_wdata_i[IRQ_W-1:0];
                default:        ;
            endcase
        end

        // a new event in the clearing cycle survives the clear
        next_st.irq_status = (st.irq_status & ~clr);
        next_st.irq_status[IRQ_ONSET] = next_st.irq_status[IRQ_ONSET] | onset;
        next_st.irq_status[IRQ_FALL]  = next_st.irq_status[IRQ_FALL] | fall;

        if (reg_rd_i) begin
            case (reg_addr_i)
                IMB_TRIM_OFS:   next_st.rdata = st.imb;
                OVERRANGE_ENABLE_OFS:     next_st.rdata = st.en;
                OVERRANGE_HOLD_CTL_OFS:   next_st.rdata = st.hold;
                OVERRANGE_THRESHOLD_OFS:     next_st.rdata = st.th;
                IRQ_STATUS_OFS: next_st.rdata = {6'h00, st.irq_status};
                IRQ_ENABLE_OFS: next_st.rdata = {6'h00, st.irq_enable};
                default:        next_st.rdata = 8'h00;
            endcase
        end

        // pipeline advances only on sampling ticks; disable flushes it
        if (!en_bit) begin
            next_st.dly = '0;
        end else if (sample_valid_i) begin
            next_st.dly = {st.dly[OVR_LATENCY-2:0], over_raw};
        end

        // run of low samples seen while the indicator is still up
        if (!en_bit) begin
            next_st.run = 5'h00;
        end else if (sample_valid_i) begin
            if (raw_late) begin
                next_st.run = 5'h00;
            end else if (ind) begin
                next_st.run = 5'(st.run + 5'h01);
            end
        end
    end

    // all fields clear to the documented zero reset value
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o              = st.rdata;
    assign overrange_indicator_o    = ind;
    assign serial_data_out_pin_o    = ind && en_bit;
    assign serial_data_out_pin_oe_o = en_bit;
    assign irq_o                    = |(st.irq_status & st.irq_enable);

    amp_decode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (st.imb[AMP_MSB:AMP_LSB] == 3'h7) |=> (pos_term_ohm_o == 8'sh1e && neg_term_ohm_o == -8'sh1e))
        else $error("amplitude code 7 not decoded to 30 ohm");

    amp_reverse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (st.imb[AMP_MSB:AMP_LSB] == 3'h1) |=> (pos_term_ohm_o == -8'sh0a && neg_term_ohm_o == 8'sh0a))
        else $error("amplitude code 1 not decoded to -10 ohm");

    phase_decode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (st.imb[PH_MSB:PH_LSB] == 4'hf) |=> (neg_cap_ff_o == 11'h690 && pos_cap_ff_o == 11'h000))
        else $error("phase code 15 not decoded to 1.68 pF");

    phase_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (st.imb[PH_MSB:PH_LSB] == 4'h1) |=> (pos_cap_ff_o == 11'h0f0 && neg_cap_ff_o == 11'h000))
        else $error("phase code 1 not decoded to 0.24 pF");

    disable_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!en_bit && !$past(en_bit)) |-> (!ind && !serial_data_out_pin_o && st.dly == '0))
        else $error("indicator active while disabled");

    full_scale_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (en_bit && sample_valid_i && st.th == 8'h00 && sample_i == 16'h7fff) |=> st.dly[0])
        else $error("full-scale sample not flagged");

    hold_extend_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ($fell(ind) && en_bit && $past(en_bit) && $stable(hold_code))
        |-> (st.run == 5'(hold_ext(hold_code)) + 5'h01))
        else $error("hold extension length wrong");

    fixed_latency_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ($rose(ind) |-> $past(raw_late)) and ($fell(ind) && $past(en_bit) |-> !$past(raw_late)))
        else $error("indicator edge not tied to pipeline output");

    enable_reset_a: assert property (@(posedge sys_clk_i)
        !resetn_i |-> (st.en == REG_RESET && !serial_data_out_pin_oe_o))
        else $error("enable register not zero in reset");

    hold_reset_a: assert property (@(posedge sys_clk_i)
        !resetn_i |-> (st.hold == REG_RESET))
        else $error("hold register not zero in reset");

    threshold_below_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (en_bit && sample_valid_i && st.th == 8'h01 && sample_i == 16'h7f7e) |=> !st.dly[0])
        else $error("sample inside threshold flagged");

    threshold_at_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (en_bit && sample_valid_i && st.th == 8'h01 && sample_i == 16'h8080) |=> st.dly[0])
        else $error("sample at negative threshold missed");

    irq_set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (onset && reg_wr_i && reg_addr_i == IRQ_CLEAR_OFS) |=> st.irq_status[IRQ_ONSET])
        else $error("onset event lost to clear");

endmodule

// *** dv/input_trim_overrange_regs_bench.sv ***
`timescale 1ns/1ns
module input_trim_overrange_regs_bench;
    import ovr_pkg::*;

    typedef struct {
        logic [7:0]  w;
        logic signed [7:0] pt;
        logic signed [7:0] nt;
        logic [10:0] pc;
        logic [10:0] nc;
        logic        rs;
    } trim_row_t;

    logic               sys_clk_i;
    logic               resetn_i = 1'b1;
    logic [7:0]         reg_addr_i;
    logic [7:0]         reg_wdata_i;
    logic               reg_wr_i;
    logic               reg_rd_i;
    logic [7:0]         reg_rdata_o;
    logic [15:0]        sample_i;
    logic               sample_valid_i;
    logic               overrange_indicator_o;
    logic               serial_data_out_pin_o;
    logic               serial_data_out_pin_oe_o;
    logic signed [7:0]  pos_term_ohm_o;
    logic signed [7:0]  neg_term_ohm_o;
    logic [10:0]        pos_cap_ff_o;
    logic [10:0]        neg_cap_ff_o;
    logic               trim_reserved_o;
    logic               irq_o;
    int                 mismatches = 0;
    int                 cmp_count  = 0;
    logic [7:0]         rd_val;
    logic [7:0]         rd_after;
    int                 first;
    int                 highs;
    int                 rises;
    trim_row_t          rows [8];
    logic [15:0]        th_smp [6];
    logic [7:0]         th_val [6];
    logic [3:0]         ext_exp [4];

    input_trim_overrange_regs dut_u (
        .sys_clk_i                (sys_clk_i),
        .resetn_i                 (resetn_i),
        .reg_addr_i               (reg_addr_i),
        .reg_wdata_i              (reg_wdata_i),
        .reg_wr_i                 (reg_wr_i),
        .reg_rd_i                 (reg_rd_i),
        .reg_rdata_o              (reg_rdata_o),
        .sample_i                 (sample_i),
        .sample_valid_i           (sample_valid_i),
        .overrange_indicator_o    (overrange_indicator_o),
        .serial_data_out_pin_o    (serial_data_out_pin_o),
        .serial_data_out_pin_oe_o (serial_data_out_pin_oe_o),
        .pos_term_ohm_o           (pos_term_ohm_o),
        .neg_term_ohm_o           (neg_term_ohm_o),
        .pos_cap_ff_o             (pos_cap_ff_o),
        .neg_cap_ff_o             (neg_cap_ff_o),
        .trim_reserved_o          (trim_reserved_o),
        .irq_o                    (irq_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // strobe is lowered one edge before the task returns so back-to-back calls never double-drive it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        rd_val = reg_rdata_o;
        @(negedge sys_clk_i);
        rd_after = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask

    // one event at cycle 0, optional second at sec; per=2 gives a sampling tick every other clock
    // inputs move right after a rising edge; pass k looks at what the edge taking sample k-1 launched
    task automatic run(input logic [15:0] s, input int sec, input int per);
        logic prev;
        prev  = 1'b0;
        first = -1;
        highs = 0;
        rises = 0;
        for (int k = 0; k <= 48; k++) begin
            sample_valid_i <= (k < 48) && (k % per == 0);
            sample_i       <= (k == 0 || k == sec) ? s : 16'h0000;
            @(negedge sys_clk_i);
            if (k > 0) begin
                chk("sdo_pin", serial_data_out_pin_o, overrange_indicator_o);
                if (overrange_indicator_o === 1'b1) begin
                    highs++;
                    if (first < 0) first = k - 1;
                    if (!prev) rises++;
                end
                prev = overrange_indicator_o;
            end
            @(posedge sys_clk_i);
        end
    endtask

    initial begin
        // reset falls after time zero so the asynchronous branch sees a real edge
        #1 resetn_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        sample_i = 16'h0000;
        sample_valid_i = 1'b0;
        rows = '{'{8'h00, 8'h00, 8'h00, 11'h000, 11'h000, 1'b0}, '{8'h71, 8'h1e, 8'he2, 11'h0f0, 11'h000, 1'b0},
                 '{8'h6f, 8'h14, 8'hec, 11'h000, 11'h690, 1'b0}, '{8'h5a, 8'h0a, 8'hf6, 11'h000, 11'h1e0, 1'b0},
                 '{8'h47, 8'h00, 8'h00, 11'h690, 11'h000, 1'b1}, '{8'h39, 8'he2, 8'h1e, 11'h000, 11'h0f0, 1'b0},
                 '{8'h22, 8'hec, 8'h14, 11'h1e0, 11'h000, 1'b0}, '{8'h18, 8'hf6, 8'h0a, 11'h000, 11'h000, 1'b1}};
        th_smp = '{16'h7f7f, 16'h7f7e, 16'h8080, 16'h8081, 16'h7ffe, 16'h8000};
        th_val = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
        ext_exp = '{4'h0, 4'h3, 4'h7, 4'hf};
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            wr(IMB_TRIM_OFS, rows[i].w);
            @(posedge sys_clk_i);
            chk("pos_term", pos_term_ohm_o, rows[i].pt);
            chk("neg_term", neg_term_ohm_o, rows[i].nt);
            chk("pos_cap", pos_cap_ff_o, rows[i].pc);
            chk("neg_cap", neg_cap_ff_o, rows[i].nc);
            chk("trim_rsvd", trim_reserved_o, rows[i].rs);
            rd(IMB_TRIM_OFS);
            chk("trim_read", rd_val, rows[i].w);
        end
        rd(OVERRANGE_ENABLE_OFS);
        chk("en_reset", rd_val, REG_RESET);
        rd(OVERRANGE_HOLD_CTL_OFS);
        chk("hold_reset", rd_val, REG_RESET);
        chk("hold_rd_once", rd_after, 8'h00);
        rd(OVERRANGE_THRESHOLD_OFS);
        chk("th_reset", rd_val, REG_RESET);
        run(16'h7fff, 0, 1);
        chk("off_highs", highs, 0);
        chk("off_oe", serial_data_out_pin_oe_o, 1'b0);
        wr(IRQ_ENABLE_OFS, 8'h01);
        wr(OVERRANGE_ENABLE_OFS, 8'h01);
        chk("on_oe", serial_data_out_pin_oe_o, 1'b1);
        rd(OVERRANGE_ENABLE_OFS);
        chk("en_read", rd_val, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(OVERRANGE_HOLD_CTL_OFS, 8'(c));
            run(16'h7fff, 0, 1);
            chk("latency", first, OVR_LATENCY);
            chk("hold_len", highs, 1 + ext_exp[c]);
        end
        chk("irq_set", irq_o, 1'b1);
        rd(IRQ_STATUS_OFS);
        chk("irq_status", rd_val, 8'h03);
        wr(IRQ_ENABLE_OFS, 8'h00);
        chk("irq_mask", irq_o, 1'b0);
        wr(IRQ_CLEAR_OFS, 8'h03);
        rd(IRQ_STATUS_OFS);
        chk("irq_clr", rd_val, 8'h00);
        rd(IRQ_CLEAR_OFS);
        chk("clr_read", rd_val, 8'h00);
        wr(8'h55, 8'ha5);
        rd(8'h55);
        chk("unmapped", rd_val, 8'h00);
        wr(OVERRANGE_HOLD_CTL_OFS, 8'h01);
        run(16'h8000, 0, 2);
        chk("tick_units", highs, 8);
        run(16'h7fff, 4, 1);
        chk("restart_len", highs, 8);
        chk("restart_gap", rises, 1);
        wr(OVERRANGE_HOLD_CTL_OFS, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(OVERRANGE_THRESHOLD_OFS, th_val[i]);
            run(th_smp[i], 0, 1);
            chk("threshold", highs > 0, ((i % 2) == 0 && i != 4) || i == 5);
        end
        // clear write lands on the very edge that sees the indicator rise: the set must win
        sample_valid_i <= 1'b1;
        sample_i       <= 16'h7fff;
        @(posedge sys_clk_i);
        sample_i       <= 16'h0000;
        repeat (3) @(posedge sys_clk_i);
        wr(IRQ_CLEAR_OFS, 8'h03);
        rd(IRQ_STATUS_OFS);
        chk("irq_race", rd_val[IRQ_ONSET], 1'b1);
        sample_valid_i <= 1'b0;
        resetn_i <= 1'b0;
        @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(OVERRANGE_ENABLE_OFS);
        chk("en_rereset", rd_val, REG_RESET);
        chk("oe_rereset", serial_data_out_pin_oe_o, 1'b0);
        conclude();
    end

    // whole sequence needs well under 3000 cycles
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule
